/* core/dtm_pkg.sv */
// Shared constants and carrier types of the dual timer block
package dtm_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int TICK_DIV_DEF = 6;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_BCTL = 8'h88;
    localparam logic [7:0] IDX_BMODE = 8'h89;
    localparam logic [7:0] IDX_T0L = 8'h8a;
    localparam logic [7:0] IDX_T1L = 8'h8b;
    localparam logic [7:0] IDX_T0H = 8'h8c;
    localparam logic [7:0] IDX_T1H = 8'h8d;
    localparam logic [7:0] IDX_T2CTL = 8'hc8;
    localparam logic [7:0] IDX_T2MC = 8'hc9;
    localparam logic [7:0] IDX_CAPL = 8'hca;
    localparam logic [7:0] IDX_CAPH = 8'hcb;
    localparam logic [7:0] IDX_T2L = 8'hcc;
    localparam logic [7:0] IDX_T2H = 8'hcd;

    // Basic timers mode register fields
    localparam int BM_GATE1 = 7;
    localparam int BM_CT1 = 6;
    localparam int BM_MODE1 = 4;
    localparam int BM_GATE0 = 3;
    localparam int BM_CT0 = 2;
    localparam int BM_MODE0 = 0;
    // Basic timers control register fields
    localparam int BC_OVF1 = 7;
    localparam int BC_RUN1 = 6;
    localparam int BC_OVF0 = 5;
    localparam int BC_RUN0 = 4;
    // Third timer control fields
    localparam int T2_TF = 7;
    localparam int T2_EXF = 6;
    localparam int T2_RCLK = 5;
    localparam int T2_TXSEL = 4;
    localparam int T2_EXEN = 3;
    localparam int T2_TR = 2;
    localparam int T2_CT = 1;
    localparam int T2_CPRL = 0;
    // Third timer mode control fields
    localparam int T2M_OE = 1;
    localparam int T2M_DOWN = 0;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_T2MC = 2'h0;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    typedef enum logic [1:0] {
        DTM_MODE_13BIT  = 2'b00,
        DTM_MODE_16BIT  = 2'b01,
        DTM_MODE_RELOAD = 2'b10,
        DTM_MODE_SPLIT  = 2'b11
    } dtm_mode_t;

    // Pin input indices into the pins vector
    localparam int PIN_GATE0 = 0;
    localparam int PIN_GATE1 = 1;
    localparam int PIN_CNT0 = 2;
    localparam int PIN_CNT1 = 3;
    localparam int PIN_T2CLK = 4;
    localparam int PIN_TRIG = 5;
    localparam int PIN_N = 6;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } dtm_apb_req_t;

    typedef struct packed {
        logic ovf;
        logic [7:0] h;
        logic [7:0] l;
    } dtm_step_t;
endpackage : dtm_pkg

/* core/dtm_tick_div.sv */
// Machine cycle enable divider
`timescale 1ns/1ns
module dtm_tick_div import dtm_pkg::*; #(
    parameter int DIV = TICK_DIV_DEF
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       tick;
    } dtm_div_t;

    dtm_div_t s_ff;
    dtm_div_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.tick = (s_ff.cnt == 8'(DIV - 1));
        nxt_s.cnt = nxt_s.tick ? 8'h00 : s_ff.cnt + 8'h01;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign tick = s_ff.tick;
endmodule : dtm_tick_div

/* core/dtm_fall_det.sv */
// Falling edge detectors for sampled pin inputs
`timescale 1ns/1ns
module dtm_fall_det import dtm_pkg::*; #(
    parameter int W = PIN_N
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] lvl,
    output logic      [W-1:0] fall
);
    typedef struct packed {
        logic [W-1:0] prev;
    } dtm_fd_t;

    dtm_fd_t s_ff;
    dtm_fd_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.prev = lvl;
    end

    // Previous sample clears at reset so a pin held low is not seen as an edge
    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign fall = s_ff.prev & ~lvl;
endmodule : dtm_fall_det

/* core/dtm_timers.sv */
// Two basic timers and the third timer with APB register access
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ns
module dtm_timers import dtm_pkg::*; #(
    parameter int TICK_DIV = TICK_DIV_DEF
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  dtm_apb_req_t           apb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [PIN_N-1:0]  pins,
    output logic                   basic_overflow_flag0,
    output logic                   basic_overflow_flag1,
    output logic                   third_overflow_flag,
    output logic                   third_external_flag,
    output logic                   ovf0_pulse,
    output logic                   ovf1_pulse,
    output logic                   ovf2_pulse,
    output logic                   uart_rx_clk,
    output logic                   uart_tx_clk,
    output logic                   clock_out
);
    typedef struct packed {
        logic [7:0]        bmode;
        logic              tf0;
        logic              tf1;
        logic              tr0;
        logic              tr1;
        logic [7:0]        t0l;
        logic [7:0]        t0h;
        logic [7:0]        t1l;
        logic [7:0]        t1h;
        logic [7:0]        third_timer_control;
        logic [1:0]        third_timer_mode_control;
        logic [7:0]        capl;
        logic [7:0]        caph;
        logic [15:0]       t2cnt;
        logic [DATA_W-1:0] rdata;
        logic              ready;
        logic              err;
        logic              ovf0;
        logic              ovf1;
        logic              ovf2;
        logic              rxclk;
        logic              txclk;
        logic              cout;
    } dtm_state_t;

    dtm_state_t       s_ff;
    dtm_state_t       nxt_s;
    logic             tick;
    logic [PIN_N-1:0] fall;

    dtm_tick_div #(
        .DIV (TICK_DIV)
    ) u_div (
        .clk  (clk),
        .rst  (rst),
        .tick (tick)
    );

    dtm_fall_det #(
        .W (PIN_N)
    ) u_fall (
        .clk  (clk),
        .rst  (rst),
        .lvl  (pins),
        .fall (fall)
    );

    // One count step of a basic timer in the given mode
    function automatic dtm_step_t bt_step(
        input logic [1:0] m,
        input logic [7:0] l,
        input logic [7:0] h
    );
        dtm_step_t   r;
        logic [12:0] c13;
        logic [15:0] c16;
        r = {1'b0, h, l};
        c13 = {h, l[4:0]};
        c16 = {h, l};
        case (dtm_mode_t'(m))
            DTM_MODE_13BIT: begin
                // Upper three low-byte bits are left as they are
                r.ovf = &c13;
                c13 = c13 + 13'h0001;
                r.h = c13[12:5];
                r.l = {l[7:5], c13[4:0]};
            end
            DTM_MODE_16BIT: begin
                r.ovf = &c16;
                c16 = c16 + 16'h0001;
                r.h = c16[15:8];
                r.l = c16[7:0];
            end
            DTM_MODE_RELOAD: begin
                r.ovf = &l;
                r.l = r.ovf ? h : l + 8'h01;
            end
            DTM_MODE_SPLIT: begin
                r.ovf = &l;
                r.l = l + 8'h01;
            end
            default: begin
                r = {1'b0, h, l};
            end
        endcase
        return r;
    endfunction : bt_step

    logic        hit;
    logic        wr;
    logic [7:0]  idx;
    logic [7:0]  wd;
    logic [7:0]  rd;
    logic [1:0]  m0;
    logic [1:0]  m1;
    logic        split;
    logic        en0;
    logic        en1;
    logic        inc0;
    logic        inc1;
    logic        inch;
    logic        set_tf0;
    logic        set_tf1;
    logic        t1_ovf;
    dtm_step_t   r0;
    dtm_step_t   r1;
    logic        baud;
    logic        coutm;
    logic        capm;
    logic        relm;
    logic        updn;
    logic        inc2;
    logic        trg;
    logic        o2;
    logic        set_exf;
    logic        tog_exf;
    logic [15:0] cap;

    always_comb begin
        nxt_s = s_ff;
        hit = 1'b0;
        rd = 8'h00;
        idx = apb.paddr[9:2];
        wd = apb.pwdata[7:0];
        nxt_s.ovf0 = 1'b0;
        nxt_s.ovf1 = 1'b0;
        nxt_s.ovf2 = 1'b0;

        // Register read decode
        if (apb.paddr[1:0] == 2'b00 && apb.paddr[ADDR_W-1:10] == '0) begin
            hit = 1'b1;
            case (idx)
                IDX_BCTL:  rd = {s_ff.tf1, s_ff.tr1, s_ff.tf0, s_ff.tr0, 4'h0};
                IDX_BMODE: rd = s_ff.bmode;
                IDX_T0L:   rd = s_ff.t0l;
                IDX_T1L:   rd = s_ff.t1l;
                IDX_T0H:   rd = s_ff.t0h;
                IDX_T1H:   rd = s_ff.t1h;
                IDX_T2CTL: rd = s_ff.third_timer_control;
                IDX_T2MC:  rd = {6'h00, s_ff.third_timer_mode_control};
                IDX_CAPL:  rd = s_ff.capl;
                IDX_CAPH:  rd = s_ff.caph;
                IDX_T2L:   rd = s_ff.t2cnt[7:0];
                IDX_T2H:   rd = s_ff.t2cnt[15:8];
                default:   hit = 1'b0;
            endcase
        end
        // One wait-free access: answer in the first access cycle
        nxt_s.ready = apb.psel & ~apb.penable;
        nxt_s.err = apb.psel & ~apb.penable & ~hit;
        nxt_s.rdata = (apb.psel & ~apb.penable & ~apb.pwrite) ? {24'h000000, rd} : '0;
        wr = apb.psel & apb.penable & s_ff.ready & apb.pwrite & hit;

        // Basic timers
        m0 = s_ff.bmode[BM_MODE0+:2];
        m1 = s_ff.bmode[BM_MODE1+:2];
        split = (dtm_mode_t'(m0) == DTM_MODE_SPLIT);
        en0 = s_ff.tr0 & (~s_ff.bmode[BM_GATE0] | pins[PIN_GATE0]);
        // With the first timer split, the second one has lost its run bit
        en1 = (split | s_ff.tr1)
            & (~s_ff.bmode[BM_GATE1] | pins[PIN_GATE1])
            & (dtm_mode_t'(m1) != DTM_MODE_SPLIT);
        inc0 = en0 & (s_ff.bmode[BM_CT0] ? fall[PIN_CNT0] : tick);
        inc1 = en1 & (s_ff.bmode[BM_CT1] ? fall[PIN_CNT1] : tick);
        inch = split & s_ff.tr1 & tick;
        r0 = bt_step(m0, s_ff.t0l, s_ff.t0h);
        r1 = bt_step(m1, s_ff.t1l, s_ff.t1h);
        set_tf0 = 1'b0;
        set_tf1 = 1'b0;
        t1_ovf = inc1 & r1.ovf;
        if (inc0) begin
            nxt_s.t0l = r0.l;
            set_tf0 = r0.ovf;
            if (!split) begin
                nxt_s.t0h = r0.h;
            end
        end
        if (inch) begin
            nxt_s.t0h = s_ff.t0h + 8'h01;
            set_tf1 = &s_ff.t0h;
        end
        if (inc1) begin
            nxt_s.t1l = r1.l;
            nxt_s.t1h = r1.h;
            if (!split) begin
                set_tf1 = r1.ovf;
            end
        end
        nxt_s.ovf0 = set_tf0;
        nxt_s.ovf1 = t1_ovf;
        nxt_s.tf0 = s_ff.tf0 | set_tf0;
        nxt_s.tf1 = s_ff.tf1 | set_tf1;

        // Third timer mode decode
        baud = s_ff.third_timer_control[T2_RCLK] | s_ff.third_timer_control[T2_TXSEL];
        coutm = ~baud & ~s_ff.third_timer_control[T2_CPRL] & s_ff.third_timer_mode_control[T2M_OE];
        capm = ~baud & s_ff.third_timer_control[T2_CPRL];
        relm = ~baud & ~s_ff.third_timer_control[T2_CPRL] & ~s_ff.third_timer_mode_control[T2M_OE];
        updn = relm & s_ff.third_timer_mode_control[T2M_DOWN];
        cap = {s_ff.caph, s_ff.capl};
        // Baud generation counts every clock when on the internal source
        if (!s_ff.third_timer_control[T2_TR]) begin
            inc2 = 1'b0;
        end else if (s_ff.third_timer_control[T2_CT]) begin
            inc2 = fall[PIN_T2CLK];
        end else begin
            inc2 = baud ? 1'b1 : tick;
        end
        // In up/down use the trigger pin is the direction, not an event
        trg = s_ff.third_timer_control[T2_TR] & s_ff.third_timer_control[T2_EXEN] & fall[PIN_TRIG]
            & ~coutm & ~updn;
        o2 = 1'b0;
        if (inc2) begin
            if (updn && !pins[PIN_TRIG]) begin
                if (s_ff.t2cnt == cap) begin
                    o2 = 1'b1;
                    nxt_s.t2cnt = CNT_MAX;
                end else begin
                    nxt_s.t2cnt = s_ff.t2cnt - 16'h0001;
                end
            end else if (s_ff.t2cnt == CNT_MAX) begin
                o2 = 1'b1;
                nxt_s.t2cnt = capm ? 16'h0000 : cap;
            end else begin
                nxt_s.t2cnt = s_ff.t2cnt + 16'h0001;
            end
        end
        if (trg && capm) begin
            nxt_s.capl = s_ff.t2cnt[7:0];
            nxt_s.caph = s_ff.t2cnt[15:8];
        end
        if (trg && relm) begin
            nxt_s.t2cnt = cap;
        end
        nxt_s.ovf2 = o2;
        if (coutm && o2) begin
            nxt_s.cout = ~s_ff.cout;
        end
        set_exf = trg;
        tog_exf = updn & o2;
        nxt_s.third_timer_control[T2_TF] = s_ff.third_timer_control[T2_TF] | (o2 & ~baud & ~coutm);
        nxt_s.third_timer_control[T2_EXF] = (s_ff.third_timer_control[T2_EXF] ^ tog_exf) | set_exf;
        nxt_s.rxclk = s_ff.third_timer_control[T2_RCLK] ? o2 : t1_ovf;
        nxt_s.txclk = s_ff.third_timer_control[T2_TXSEL] ? o2 : t1_ovf;

        // Software writes; hardware flag sets win over a clear
        if (wr) begin
            case (idx)
                IDX_BCTL: begin
                    nxt_s.tf1 = wd[BC_OVF1] | set_tf1;
                    nxt_s.tr1 = wd[BC_RUN1];
                    nxt_s.tf0 = wd[BC_OVF0] | set_tf0;
                    nxt_s.tr0 = wd[BC_RUN0];
                end
                IDX_BMODE: nxt_s.bmode = wd;
                IDX_T0L:   nxt_s.t0l = wd;
                IDX_T1L:   nxt_s.t1l = wd;
                IDX_T0H:   nxt_s.t0h = wd;
                IDX_T1H:   nxt_s.t1h = wd;
                IDX_T2CTL: begin
                    nxt_s.third_timer_control = wd;
                    nxt_s.third_timer_control[T2_TF] = wd[T2_TF] | (o2 & ~baud & ~coutm);
                    nxt_s.third_timer_control[T2_EXF] = (wd[T2_EXF] ^ tog_exf) | set_exf;
                end
                IDX_T2MC:  nxt_s.third_timer_mode_control = wd[1:0];
                IDX_CAPL:  nxt_s.capl = wd;
                IDX_CAPH:  nxt_s.caph = wd;
                IDX_T2L:   nxt_s.t2cnt[7:0] = wd;
                IDX_T2H:   nxt_s.t2cnt[15:8] = wd;
                default:   nxt_s.err = s_ff.err;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_ff <= '0;
            s_ff.bmode <= RST_BYTE;
            s_ff.third_timer_control <= RST_BYTE;
            s_ff.third_timer_mode_control <= RST_T2MC;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.rdata;
    assign pready = s_ff.ready;
    assign pslverr = s_ff.err;
    assign basic_overflow_flag0 = s_ff.tf0;
    assign basic_overflow_flag1 = s_ff.tf1;
    assign third_overflow_flag = s_ff.third_timer_control[T2_TF];
    assign third_external_flag = s_ff.third_timer_control[T2_EXF];
    assign ovf0_pulse = s_ff.ovf0;
    assign ovf1_pulse = s_ff.ovf1;
    assign ovf2_pulse = s_ff.ovf2;
    assign uart_rx_clk = s_ff.rxclk;
    assign uart_tx_clk = s_ff.txclk;
    assign clock_out = s_ff.cout;
endmodule : dtm_timers

/* dv/dtm_timers_chk.sv */
// Port-level assertions for the dual timer block
`timescale 1ns/1ns
module dtm_timers_chk import dtm_pkg::*; #(
    parameter int TICK_DIV = TICK_DIV_DEF
) (
    input wire logic              clk,
    input wire logic              rst,
    input dtm_apb_req_t           apb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [PIN_N-1:0]  pins,
    input wire logic              basic_overflow_flag0,
    input wire logic              basic_overflow_flag1,
    input wire logic              third_overflow_flag,
    input wire logic              third_external_flag,
    input wire logic              ovf0_pulse,
    input wire logic              ovf1_pulse,
    input wire logic              ovf2_pulse,
    input wire logic              uart_rx_clk,
    input wire logic              uart_tx_clk,
    input wire logic              clock_out
);
    // Shadows of software-only bits; flags are left out since hardware sets them
    logic [7:0] t2c_ff;
    logic [7:0] bm_ff;
    logic       dc_ff;
    logic [3:0] trg_ff;
    wire logic       acc = apb.psel && apb.penable && pready && apb.pwrite;
    wire logic       wr_t2 = acc && apb.paddr == {2'h0, IDX_T2CTL, 2'h0};
    wire logic       wr_bc = acc && apb.paddr == {2'h0, IDX_BCTL, 2'h0};
    wire logic [7:0] ix = apb.paddr[9:2];
    wire logic       mapped = apb.paddr[11:10] == 2'h0 && apb.paddr[1:0] == 2'h0
        && (ix inside {[8'h88:8'h8d], [8'hc8:8'hcd]});
    wire logic       baud = t2c_ff[T2_RCLK] | t2c_ff[T2_TXSEL];
    wire logic       fell = |(trg_ff[3:1] & ~trg_ff[2:0]) | (trg_ff[0] & ~pins[PIN_TRIG]);
    always_ff @(posedge clk) begin
        if (rst) begin
            t2c_ff <= 8'h00;
            bm_ff <= 8'h00;
            dc_ff <= 1'b0;
            trg_ff <= 4'h0;
        end else begin
            trg_ff <= {trg_ff[2:0], pins[PIN_TRIG]};
            if (wr_t2) t2c_ff <= apb.pwdata[7:0];
            if (acc && apb.paddr == {2'h0, IDX_BMODE, 2'h0}) bm_ff <= apb.pwdata[7:0];
            if (acc && apb.paddr == {2'h0, IDX_T2MC, 2'h0}) dc_ff <= apb.pwdata[T2M_DOWN];
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    a_apb_no_wait: assert property (apb.psel && !apb.penable |=> pready)
        else $error("pready missing after setup");
    a_err_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address map");
    a_rst_clear: assert property (disable iff (1'b0) rst |=> !(basic_overflow_flag0
        | basic_overflow_flag1 | third_overflow_flag | third_external_flag))
        else $error("flag set after reset");
    a_tf0_from_ovf: assert property (ovf0_pulse |-> ##[0:1] basic_overflow_flag0)
        else $error("overflow without flag");
    a_tf0_sticky: assert property (basic_overflow_flag0 && !wr_bc |=> basic_overflow_flag0)
        else $error("basic flag lost");
    a_tf2_sticky: assert property (third_overflow_flag && !wr_t2 |=> third_overflow_flag)
        else $error("third flag lost");
    a_tf2_not_baud: assert property (baud && $past(baud) && !$past(wr_t2)
        |-> !$rose(third_overflow_flag)) else $error("third flag set in baud mode");
    a_rx_route: assert property ($stable(t2c_ff[T2_RCLK]) |-> uart_rx_clk
        == (t2c_ff[T2_RCLK] ? ovf2_pulse : ovf1_pulse)) else $error("rx clock misrouted");
    a_tx_route: assert property ($stable(t2c_ff[T2_TXSEL]) |-> uart_tx_clk
        == (t2c_ff[T2_TXSEL] ? ovf2_pulse : ovf1_pulse)) else $error("tx clock misrouted");
    a_tr2_off: assert property (!t2c_ff[T2_TR] && !$past(t2c_ff[T2_TR]) |-> !ovf2_pulse)
        else $error("third timer ran while off");
    a_t1_mode3: assert property (bm_ff[5:4] == 2'b11 && $past(bm_ff[5:4]) == 2'b11
        |-> !ovf1_pulse) else $error("second timer ran in mode 3");
    a_ext_on_fall: assert property ($rose(third_external_flag) && !$past(wr_t2)
        && !dc_ff && !$past(dc_ff) |-> fell) else $error("external flag without trigger fall");
    c_t2_ovf: cover property (ovf2_pulse);
    c_ext: cover property ($rose(third_external_flag));
    c_urx: cover property (uart_rx_clk);
endmodule : dtm_timers_chk
bind dtm_timers dtm_timers_chk #(.TICK_DIV(TICK_DIV)) i_dtm_timers_chk (
    .clk(clk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins(pins), .basic_overflow_flag0(basic_overflow_flag0),
    .basic_overflow_flag1(basic_overflow_flag1), .third_overflow_flag(third_overflow_flag),
    .third_external_flag(third_external_flag), .ovf0_pulse(ovf0_pulse),
    .ovf1_pulse(ovf1_pulse), .ovf2_pulse(ovf2_pulse), .uart_rx_clk(uart_rx_clk),
    .uart_tx_clk(uart_tx_clk), .clock_out(clock_out)
);

/* dv/dtm_pin_model.sv */
// Pin-side model: gate levels, third timer clock pin and trigger pin
`timescale 1ns/1ns
module dtm_pin_model import dtm_pkg::*; (
    input  wire logic [1:0]       gate,
    input  wire logic             clk,
    output logic      [PIN_N-1:0] pins
);
    logic trg_ff = 1'b1;
    logic t2c_ff = 1'b0;
    // Basic count pins stay low: counter mode of the basic timers is not exercised
    assign pins = {trg_ff, t2c_ff, 2'b00, gate};
    // Six cycles a level: a twelve-cycle period keeps to the external rate limit
    task automatic hold_lvl(input logic t, input logic c);
        @(posedge clk);
        trg_ff <= t;
        t2c_ff <= c;
        repeat (5) @(posedge clk);
    endtask : hold_lvl
    task automatic trig_fall();
        hold_lvl(1'b1, t2c_ff);
        hold_lvl(1'b0, t2c_ff);
        hold_lvl(1'b1, t2c_ff);
    endtask : trig_fall
    task automatic clk_falls(input int n);
        repeat (n) begin
            hold_lvl(trg_ff, 1'b1);
            hold_lvl(trg_ff, 1'b0);
        end
    endtask : clk_falls
endmodule : dtm_pin_model

/* dv/tb.sv */
// Self-checking bench for the dual timer block
`timescale 1ns/1ns
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb import dtm_pkg::*;;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    dtm_apb_req_t      apb = '0;
    logic [DATA_W-1:0] prdata;
    logic              pready, pslverr;
    logic [PIN_N-1:0]  pins;
    logic [1:0]        gate = 2'b11;
    logic              f0, f1, f2, fx, o0, o1, o2, urx, utx, cko;
    logic [7:0]        rd;
    logic              err, seen;
    int                error_cnt = 0;
    int                checked = 0;
    wire logic [7:0]   mon = {cko, utx, urx, o2, fx, f2, f1, f0};
    always #20 clk = ~clk;
    dtm_timers #(.TICK_DIV(TICK_DIV_DEF)) i_dtm_timers (
        .clk(clk), .rst(rst), .apb(apb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .basic_overflow_flag0(f0),
        .basic_overflow_flag1(f1), .third_overflow_flag(f2), .third_external_flag(fx),
        .ovf0_pulse(o0), .ovf1_pulse(o1), .ovf2_pulse(o2), .uart_rx_clk(urx),
        .uart_tx_clk(utx), .clock_out(cko)
    );
    dtm_pin_model i_dtm_pin_model (.gate(gate), .clk(clk), .pins(pins));
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic xfer(input logic w, input logic [7:0] ix, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        apb <= '{1'b1, 1'b0, w, {2'h0, ix, 2'h0}, {24'h0, d}};
        @(posedge clk);
        apb.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata[7:0];
        err = pslverr;
        apb <= '0;
        if (pready !== 1'b1) begin
            $display("Error at %0t: no pready", $time);
            error_cnt++;
            report_and_stop();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        xfer(1'b1, ix, d);
    endtask : wr
    task automatic rdchk(input logic [7:0] ix, input logic [7:0] e);
        xfer(1'b0, ix, 8'h00);
        `CHK(err, 1'b0)
        `CHK(rd, e)
    endtask : rdchk
    task automatic wait_hi(input int k, input int lim);
        seen = 1'b0;
        for (int i = 0; i < lim && seen !== 1'b1; i++) begin
            @(posedge clk);
            seen = mon[k];
        end
    endtask : wait_hi
    task automatic tdone(input string s);
        $display("Test %s done, mismatches so far %0d", s, error_cnt);
    endtask : tdone
    task automatic bcase(input logic [7:0] t, md, h, l, input logic g, ov,
                         input logic [7:0] eh);
        wr(IDX_BCTL, 8'h00);
        wr(IDX_BMODE, md);
        wr(IDX_T0L + t, l);
        wr(IDX_T0H + t, h);
        gate <= {g, g};
        wr(IDX_BCTL, t != 0 ? 8'h40 : 8'h10);
        rdchk(IDX_T0H + t, h);
        wait_hi(int'(t), 40);
        `CHK(seen, ov)
        wr(IDX_BCTL, 8'h00);
        rdchk(IDX_T0H + t, eh);
        if ((t != 0 ? md[5:4] : md[1:0]) == 2'b10) begin
            xfer(1'b0, IDX_T0L + t, 8'h00);
            `CHK(rd[7:1], h[7:1])
        end
    endtask : bcase
    initial begin
        #2000000;
        $display("Error at %0t: run timed out", $time);
        error_cnt++;
        report_and_stop();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdchk(IDX_T2CTL, 8'h00);
        rdchk(IDX_BMODE, 8'h00);
        wr(IDX_T2MC, 8'h03);
        rdchk(IDX_T2MC, 8'h03);
        wr(IDX_T2MC, 8'h00);
        xfer(1'b0, 8'h90, 8'h00);
        `CHK(err, 1'b1)
        `CHK(rd, 8'h00)
        tdone("registers");
        bcase(0, 8'h00, 8'hff, 8'h1e, 1, 1, 8'h00);
        bcase(0, 8'h01, 8'hff, 8'h1e, 1, 0, 8'hff);
        bcase(0, 8'h01, 8'hff, 8'hfe, 1, 1, 8'h00);
        bcase(0, 8'h02, 8'h54, 8'hfe, 1, 1, 8'h54);
        bcase(0, 8'h09, 8'hff, 8'hfe, 0, 0, 8'hff);
        bcase(0, 8'h09, 8'hff, 8'hfe, 1, 1, 8'h00);
        bcase(1, 8'h10, 8'hff, 8'hfe, 0, 1, 8'h00);
        bcase(1, 8'h90, 8'hff, 8'hfe, 0, 0, 8'hff);
        bcase(1, 8'h30, 8'hff, 8'hfe, 1, 0, 8'hff);
        wr(IDX_BMODE, 8'h33);
        wr(IDX_T0H, 8'hfe);
        wr(IDX_BCTL, 8'h40);
        wait_hi(1, 40);
        `CHK(seen, 1'b1)
        `CHK(f0, 1'b0)
        wr(IDX_T1L, 8'hfe);
        wr(IDX_T1H, 8'hfe);
        wr(IDX_BMODE, 8'h23);
        wait_hi(5, 40);
        `CHK(seen, 1'b1)
        wr(IDX_BCTL, 8'h00);
        wr(IDX_BMODE, 8'h00);
        tdone("basic timers");
        wr(IDX_CAPL, 8'h34);
        wr(IDX_CAPH, 8'h12);
        wr(IDX_T2L, 8'hfe);
        wr(IDX_T2H, 8'hff);
        wr(IDX_T2CTL, 8'h04);
        wait_hi(2, 40);
        `CHK(seen, 1'b1)
        wr(IDX_T2CTL, 8'h00);
        rdchk(IDX_T2H, 8'h12);
        rdchk(IDX_T2CTL, 8'h00);
        wr(IDX_T2L, 8'hab);
        wr(IDX_T2H, 8'hcd);
        wr(IDX_T2CTL, 8'h0f);
        i_dtm_pin_model.trig_fall();
        rdchk(IDX_CAPL, 8'hab);
        rdchk(IDX_CAPH, 8'hcd);
        rdchk(IDX_T2CTL, 8'h4f);
        i_dtm_pin_model.clk_falls(3);
        rdchk(IDX_T2L, 8'hae);
        wr(IDX_T2CTL, 8'h07);
        i_dtm_pin_model.trig_fall();
        rdchk(IDX_CAPL, 8'hab);
        `CHK(fx, 1'b0)
        tdone("reload and capture");
        wr(IDX_T2CTL, 8'h00);
        wr(IDX_T2MC, 8'h01);
        wr(IDX_T2L, 8'h10);
        wr(IDX_T2H, 8'h00);
        i_dtm_pin_model.hold_lvl(1'b0, 1'b0);
        wr(IDX_T2CTL, 8'h06);
        i_dtm_pin_model.clk_falls(2);
        rdchk(IDX_T2L, 8'h0e);
        i_dtm_pin_model.hold_lvl(1'b1, 1'b0);
        i_dtm_pin_model.clk_falls(1);
        rdchk(IDX_T2L, 8'h0f);
        wr(IDX_T2CTL, 8'h00);
        wr(IDX_T2MC, 8'h00);
        tdone("up down");
        wr(IDX_CAPL, 8'hf0);
        wr(IDX_CAPH, 8'hff);
        wr(IDX_T2L, 8'hf0);
        wr(IDX_T2H, 8'hff);
        wr(IDX_T2CTL, 8'h3c);
        wait_hi(6, 60);
        `CHK(seen, 1'b1)
        i_dtm_pin_model.trig_fall();
        rdchk(IDX_T2CTL, 8'h7c);
        wr(IDX_T2CTL, 8'h00);
        wr(IDX_CAPL, 8'hf8);
        wr(IDX_T2MC, 8'h02);
        wr(IDX_T2CTL, 8'h04);
        wait_hi(7, 300);
        `CHK(seen, 1'b1)
        rdchk(IDX_T2CTL, 8'h04);
        wr(IDX_T2CTL, 8'h00);
        tdone("baud and clock out");
        report_and_stop();
    end
endmodule : tb
